// file: include/pfl_pkg.sv
// Constants and carrier types for the procedure frame linkage block
`default_nettype none
package pfl_pkg;
  // Field positions within the linkage words and the process controls register
  localparam int PFL_AW         = 32;
  localparam int PFL_RT_LSB     = 0;
  localparam int PFL_RT_MSB     = 2;
  localparam int PFL_PFP_LSB    = 4;
  localparam int PFL_ALIGN_BITS = 6;
  localparam int PFL_STATE_BIT  = 10;
  // Size of the local register save area at the bottom of each frame
  localparam logic [31:0] PFL_SAVE_BYTES = 32'h0000_0040;
  // Return-type field encodings
  localparam logic [2:0] PFL_RT_LOCAL = 3'h0;
  localparam logic [2:0] PFL_RT_FAULT = 3'h1;
  localparam logic [2:0] PFL_RT_SUPER = 3'h2;
  localparam logic [2:0] PFL_RT_INTR  = 3'h7;
  // Reset values: one frame at address zero, save area only
  localparam logic [31:0] PFL_RESET_FP = 32'h0000_0000;
  localparam logic [31:0] PFL_RESET_SP = 32'h0000_003F;
  localparam logic [31:0] PFL_RESET_R2 = 32'h0000_0000;
  localparam logic [3:0]  PFL_RESET_DEPTH = 4'h0;
  localparam int          PFL_DEPTH_DEFAULT = 8;

  typedef enum logic [1:0] {
    PFL_STK_LOCAL,
    PFL_STK_SUPER,
    PFL_STK_INTR
  } pfl_stack_type;

  typedef enum logic [1:0] {
    PFL_CALL_LOCAL,
    PFL_CALL_SUPER,
    PFL_CALL_INTR,
    PFL_CALL_FAULT
  } pfl_call_kind_type;

  // Call request from the sequencer
  typedef struct packed {
    pfl_call_kind_type kind;
    logic [31:0]       next_addr;
    logic [31:0]       frame_bytes;
  } pfl_call_req_type;

  // Linkage words r0 (link and type), r1 (stack top), r2 (resume address)
  typedef struct packed {
    logic [31:0] r0;
    logic [31:0] r1;
    logic [31:0] r2;
  } pfl_link_type;

  // One saved activation: linkage plus context that a return may restore
  typedef struct packed {
    pfl_link_type  link;
    pfl_stack_type stack;
    logic          state;
  } pfl_save_type;
endpackage
`default_nettype wire

// file: rtl/pfl_frame_calc.sv
// Frame placement: aligned base and new stack top for a fresh frame
`default_nettype none
module pfl_frame_calc
  import pfl_pkg::*;
(
  input  wire logic [31:0] first_free,
  input  wire logic [31:0] frame_bytes,
  output logic      [31:0] frame_base,
  output logic      [31:0] frame_top
);
  localparam logic [31:0] ALIGN_MASK = 32'h0000_003F;

  // Round up to the next 64-byte boundary; low six bits forced to zero
  always_comb begin
    frame_base = (first_free + ALIGN_MASK) & ~ALIGN_MASK;
  end

  // Save area always sits below any caller-requested locals
  always_comb begin
    frame_top = frame_base + PFL_SAVE_BYTES + frame_bytes - 32'h0000_0001;
  end
endmodule
`default_nettype wire

// file: rtl/pfl_linkage.sv
// Procedure call linkage and stack frame bookkeeping for the core
// Behaviour
// - A call writes the address after the call instruction into r2.
// - A call records its type in r0 bits 0 to 2.
// - A return decodes the saved type and picks the matching return path.
// - Every new frame starts on a 64-byte boundary.
// - The lowest 64 bytes of each frame hold the local register save area.
// - r1 holds the address of the last byte of the topmost frame.
// - Stacks grow upward as contiguous frames, one per active procedure.
// - Local, supervisor and interrupt stacks exist; frames go on the current one, except supervisor calls from local and interrupt calls from a program.
// - Process controls bit 10 reads 0 in a program, 1 in an interrupt.
// - r0 bits 4 to 31 hold the previous frame's first byte address.
`default_nettype none
module pfl_linkage
  import pfl_pkg::*;
#(
  parameter int DEPTH = PFL_DEPTH_DEFAULT
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             call_valid,
  input  wire pfl_call_req_type call_req,
  input  wire logic             ret_req,
  input  wire logic [31:0]      super_stack_base,
  input  wire logic [31:0]      intr_stack_base,
  output pfl_link_type          link_q,
  output logic [31:0]           frame_base_pointer_q,
  output logic [31:0]           process_controls_reg_q,
  output pfl_stack_type         stack_sel_q,
  output logic                  ret_valid_q,
  output pfl_call_kind_type     ret_kind_q,
  output logic [31:0]           ret_addr_q,
  output logic                  call_refused_q,
  output logic                  ret_refused_q,
  output logic [3:0]            depth_q
);
  // Saved activations of callers; frames below the top live only here
  pfl_save_type      save_mem [DEPTH];
  logic              state_q;
  logic              call_ok;
  logic              ret_ok;
  logic [31:0]       first_free;
  logic [31:0]       new_base;
  logic [31:0]       new_top;
  logic [2:0]        call_rt;
  pfl_save_type      popped;
  pfl_call_kind_type ret_kind;

  // Map a saved type field onto the return path to take
  function automatic pfl_call_kind_type decode_rt(input logic [2:0] rt);
    pfl_call_kind_type k;
    k = PFL_CALL_LOCAL;
    unique case (rt)
      PFL_RT_SUPER: k = PFL_CALL_SUPER;
      PFL_RT_INTR:  k = PFL_CALL_INTR;
      PFL_RT_FAULT: k = PFL_CALL_FAULT;
      default:      k = PFL_CALL_LOCAL;
    endcase
    return k;
  endfunction

  // A call on a full save stack or a return at depth zero is refused
  always_comb begin
    call_ok = call_valid && (depth_q != 4'(DEPTH));
    ret_ok  = ret_req && !call_valid && (depth_q != PFL_RESET_DEPTH);
  end

  // Type code stored with the call
  always_comb begin
    unique case (call_req.kind)
      PFL_CALL_LOCAL: call_rt = PFL_RT_LOCAL;
      PFL_CALL_SUPER: call_rt = PFL_RT_SUPER;
      PFL_CALL_INTR:  call_rt = PFL_RT_INTR;
      PFL_CALL_FAULT: call_rt = PFL_RT_FAULT;
    endcase
  end

  // Choose where the new frame starts: top of current stack or a new stack
  always_comb begin
    first_free = link_q.r1 + 32'h0000_0001;
    unique case (call_req.kind)
      PFL_CALL_SUPER:
        if (stack_sel_q == PFL_STK_LOCAL) first_free = super_stack_base;
      PFL_CALL_INTR:
        if (!state_q) first_free = intr_stack_base;
      default: ;
    endcase
  end

  pfl_frame_calc u_calc (
    .first_free  (first_free),
    .frame_bytes (call_req.frame_bytes),
    .frame_base  (new_base),
    .frame_top   (new_top)
  );

  always_comb begin
    popped   = save_mem[depth_q[$clog2(DEPTH)-1:0] - 1'b1];
    ret_kind = decode_rt(link_q.r0[PFL_RT_MSB:PFL_RT_LSB]);
  end

  // Save stack of caller linkage; no reset needed on the storage itself
  always_ff @(posedge sys_clk) begin
    if (call_ok) begin
      save_mem[depth_q[$clog2(DEPTH)-1:0]] <= '{link_q, stack_sel_q, state_q};
    end
  end

  // Nesting depth
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      depth_q <= PFL_RESET_DEPTH;
    end else if (call_ok) begin
      depth_q <= depth_q + 4'h1;
    end else if (ret_ok) begin
      depth_q <= depth_q - 4'h1;
    end
  end

  // Linkage words and frame base of the topmost frame
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_q.r0            <= '0;
      link_q.r1            <= PFL_RESET_SP;
      link_q.r2            <= PFL_RESET_R2;
      frame_base_pointer_q <= PFL_RESET_FP;
    end else if (call_ok) begin
      link_q.r0 <= {frame_base_pointer_q[31:PFL_PFP_LSB], 1'b0, call_rt};
      link_q.r1 <= new_top;
      link_q.r2 <= call_req.next_addr;
      frame_base_pointer_q <= new_base;
    end else if (ret_ok) begin
      // Caller frame base comes from the link field, realigned
      frame_base_pointer_q <= {link_q.r0[31:PFL_ALIGN_BITS],
                               {PFL_ALIGN_BITS{1'b0}}};
      link_q <= popped.link;
    end
  end

  // Active stack: local returns stay put, the others restore it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_sel_q <= PFL_STK_LOCAL;
    end else if (call_ok) begin
      if (call_req.kind == PFL_CALL_SUPER && stack_sel_q == PFL_STK_LOCAL)
        stack_sel_q <= PFL_STK_SUPER;
      else if (call_req.kind == PFL_CALL_INTR && !state_q)
        stack_sel_q <= PFL_STK_INTR;
    end else if (ret_ok && ret_kind != PFL_CALL_LOCAL) begin
      stack_sel_q <= popped.stack;
    end
  end

  // Program or interrupt state; only interrupt and fault returns restore it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= 1'b0;
    end else if (call_ok && call_req.kind == PFL_CALL_INTR) begin
      state_q <= 1'b1;
    end else if (ret_ok && (ret_kind == PFL_CALL_INTR ||
                            ret_kind == PFL_CALL_FAULT)) begin
      state_q <= popped.state;
    end
  end

  // Visible copy of the state flag; other control bits read as zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      process_controls_reg_q <= '0;
    end else begin
      process_controls_reg_q <= '0;
      process_controls_reg_q[PFL_STATE_BIT] <= (call_ok &&
          call_req.kind == PFL_CALL_INTR) ? 1'b1 :
          (ret_ok && (ret_kind == PFL_CALL_INTR ||
                      ret_kind == PFL_CALL_FAULT)) ? popped.state
                                                    : state_q;
    end
  end

  // Return report: valid pulses one cycle; kind selected and resume point hold until the next return
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ret_valid_q <= 1'b0;
      ret_kind_q  <= PFL_CALL_LOCAL;
      ret_addr_q  <= '0;
    end else begin
      ret_valid_q <= ret_ok;
      if (ret_ok) begin
        ret_kind_q <= ret_kind;
        ret_addr_q <= link_q.r2;
      end
    end
  end

  // Refusal pulses; a call beats a simultaneous return
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      call_refused_q <= 1'b0;
      ret_refused_q  <= 1'b0;
    end else begin
      call_refused_q <= call_valid && !call_ok;
      ret_refused_q  <= ret_req && !ret_ok;
    end
  end

  // Checks on the linkage behaviour; all of them run on the core clock
  default clocking pfl_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_call;
    call_ok;
  endsequence
  sequence s_ret;
    ret_ok;
  endsequence
  // A call taken, then a return taken on the very next edge
  sequence s_call_then_ret;
    s_call ##1 s_ret;
  endsequence

  AST_RESUME_ADDR: assert property (
    s_call |=> link_q.r2 == $past(call_req.next_addr))
    else $error("resume address not captured on call");
  AST_RET_TYPE: assert property (
    s_call |=> link_q.r0[PFL_RT_MSB:PFL_RT_LSB] == $past(call_rt))
    else $error("return type field wrong after call");
  // Encode on call and decode on return must give back the call kind
  AST_RET_ROUNDTRIP: assert property (
    s_call_then_ret |=> ret_valid_q &&
      ret_kind_q == $past(call_req.kind, 2))
    else $error("return path does not match saved type");
  AST_ALIGN: assert property (
    frame_base_pointer_q[5:0] == 6'h00)
    else $error("frame base not 64-byte aligned");
  AST_SAVE_AREA: assert property (
    s_call |=> link_q.r1 >= frame_base_pointer_q + 32'h0000_003F)
    else $error("frame smaller than save area");
  AST_GROW_UP: assert property (
    s_call ##0 (call_req.kind == PFL_CALL_LOCAL) |=>
      frame_base_pointer_q > $past(link_q.r1))
    else $error("local frame not above caller frame");
  AST_INTR_STACK: assert property (
    s_call ##0 (call_req.kind == PFL_CALL_INTR && !state_q) |=>
      stack_sel_q == PFL_STK_INTR)
    else $error("interrupt call did not switch stack");
  AST_STATE_FLAG: assert property (
    s_call ##0 (call_req.kind == PFL_CALL_INTR) |=>
      process_controls_reg_q[PFL_STATE_BIT] && state_q)
    else $error("state flag not set by interrupt call");
  AST_PFP_LINK: assert property (
    s_call |=> link_q.r0[31:4] == $past(frame_base_pointer_q[31:4]))
    else $error("previous frame link wrong");
  AST_RET_RESTORE: assert property (
    s_call_then_ret |=>
      frame_base_pointer_q == $past(frame_base_pointer_q, 2))
    else $error("return did not restore caller frame");
endmodule
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the procedure frame linkage block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pfl_pkg::*;
  localparam int DEPTH = 4;
  localparam logic [31:0] SSB = 32'h0000_1000;
  localparam logic [31:0] ISB = 32'h0000_2010; // Unaligned on purpose
  logic              sys_clk, rst_n, call_valid, ret_req;
  pfl_call_req_type  call_req;
  pfl_link_type      link_q;
  logic [31:0]       frame_base_pointer_q, process_controls_reg_q;
  logic [31:0]       ret_addr_q;
  pfl_stack_type     stack_sel_q, m_st;
  pfl_call_kind_type ret_kind_q;
  logic              ret_valid_q, call_refused_q, ret_refused_q, m_pc;
  logic [3:0]        depth_q;
  logic [31:0]       m_r0, m_r1, m_r2, m_fp;
  logic [7:0]        s;
  pfl_save_type      sv [DEPTH];
  int                m_d, bad_count, cmp_count;

  pfl_linkage #(.DEPTH(DEPTH)) pfl_linkage_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .call_valid(call_valid),
    .call_req(call_req), .ret_req(ret_req), .super_stack_base(SSB),
    .intr_stack_base(ISB), .link_q(link_q),
    .frame_base_pointer_q(frame_base_pointer_q),
    .process_controls_reg_q(process_controls_reg_q),
    .stack_sel_q(stack_sel_q), .ret_valid_q(ret_valid_q),
    .ret_kind_q(ret_kind_q), .ret_addr_q(ret_addr_q),
    .call_refused_q(call_refused_q), .ret_refused_q(ret_refused_q),
    .depth_q(depth_q));

  // Free-running core clock, 100 ns period
  always #50 sys_clk = ~sys_clk;

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t mismatch got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One cycle of stimulus, then the model steps and outputs are compared
  task automatic step(input logic c, input logic r,
                      input pfl_call_kind_type k);
    logic [31:0] st, fb, na, ea;
    logic [2:0]  ty;
    logic        rv, cr, rr;
    pfl_call_kind_type ek;
    s = lfsr(s);
    fb = {24'h00_0000, s};
    s = lfsr(s);
    na = {22'h00_0000, s, 2'h0};
    @(negedge sys_clk);
    call_valid = c;
    ret_req = r;
    call_req = '{kind: k, next_addr: na, frame_bytes: fb};
    @(posedge sys_clk);
    #1;
    rv = 0;
    ek = PFL_CALL_LOCAL;
    ea = 0;
    rr = r && (c || m_d == 0);
    cr = c && m_d == DEPTH;
    if (c && !cr) begin
      case (k)
        PFL_CALL_LOCAL: ty = PFL_RT_LOCAL;
        PFL_CALL_SUPER: ty = PFL_RT_SUPER;
        PFL_CALL_INTR:  ty = PFL_RT_INTR;
        default:        ty = PFL_RT_FAULT;
      endcase
      st = m_r1 + 1;
      if (k == PFL_CALL_SUPER && m_st == PFL_STK_LOCAL) st = SSB;
      if (k == PFL_CALL_INTR && !m_pc) st = ISB;
      sv[m_d].link = '{r0: m_r0, r1: m_r1, r2: m_r2};
      sv[m_d].stack = m_st;
      sv[m_d].state = m_pc;
      m_r0 = {m_fp[31:4], 1'b0, ty};
      m_fp = (st + 32'h0000_003F) & 32'hFFFF_FFC0;
      m_r1 = m_fp + PFL_SAVE_BYTES + fb - 1;
      m_r2 = na;
      // Only a program on the local stack moves to the supervisor stack
      if (k == PFL_CALL_SUPER && m_st == PFL_STK_LOCAL)
        m_st = PFL_STK_SUPER;
      // A nested interrupt stays on the interrupt stack it is already on
      if (k == PFL_CALL_INTR) begin
        if (!m_pc) m_st = PFL_STK_INTR;
        m_pc = 1'b1;
      end
      m_d++;
    end else if (r && !rr) begin
      ea = m_r2;
      case (m_r0[2:0])
        PFL_RT_FAULT: ek = PFL_CALL_FAULT;
        PFL_RT_SUPER: ek = PFL_CALL_SUPER;
        PFL_RT_INTR:  ek = PFL_CALL_INTR;
        default:      ek = PFL_CALL_LOCAL;
      endcase
      m_fp = {m_r0[31:6], 6'h00};
      m_d--;
      {m_r0, m_r1, m_r2} = sv[m_d].link;
      // Local returns keep context; supervisor restores the stack only
      if (ek != PFL_CALL_LOCAL) m_st = sv[m_d].stack;
      if (ek == PFL_CALL_INTR || ek == PFL_CALL_FAULT) m_pc = sv[m_d].state;
      rv = 1;
    end
    chk(link_q.r0, m_r0);
    chk(link_q.r1, m_r1);
    chk(link_q.r2, m_r2);
    chk(frame_base_pointer_q, m_fp);
    chk(process_controls_reg_q, {21'h00_0000, m_pc, 10'h000});
    chk({30'h0000_0000, stack_sel_q}, {30'h0000_0000, m_st});
    chk({28'h000_0000, depth_q}, m_d);
    chk({29'h0000_0000, ret_valid_q, call_refused_q, ret_refused_q},
        {29'h0000_0000, rv, cr, rr});
    if (rv) begin
      chk({30'h0000_0000, ret_kind_q}, {30'h0000_0000, ek});
      chk(ret_addr_q, ea);
    end
  endtask

  // Watchdog sized well above the planned run of under a hundred cycles
  initial begin
    #500_000;
    bad_count++;
    wrap_up();
  end

  initial begin
    sys_clk = 0;
    rst_n = 0;
    call_valid = 0;
    ret_req = 0;
    call_req = '0;
    s = 8'h37;
    {m_r0, m_r2, m_fp} = '0;
    m_r1 = PFL_RESET_SP;
    m_st = PFL_STK_LOCAL;
    m_pc = 0;
    m_d = 0;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1;
    step(0, 0, PFL_CALL_LOCAL);
    // Every call kind back to back, then a call into a full save stack
    step(1, 0, PFL_CALL_LOCAL);
    step(1, 0, PFL_CALL_SUPER);
    step(1, 0, PFL_CALL_FAULT);
    step(1, 0, PFL_CALL_INTR);
    step(1, 0, PFL_CALL_LOCAL);
    repeat (4) step(0, 1, PFL_CALL_LOCAL);
    step(0, 1, PFL_CALL_LOCAL);
    step(1, 1, PFL_CALL_LOCAL);
    // Random mix; refusals happen at both ends of the save stack
    repeat (40) begin
      s = lfsr(s);
      step(s[0], !s[0], s[1] ? PFL_CALL_FAULT : PFL_CALL_LOCAL);
    end
    repeat (5) step(0, 1, PFL_CALL_LOCAL);
    // Nested interrupt, then a supervisor call made on the interrupt stack
    step(1, 0, PFL_CALL_INTR);
    step(1, 0, PFL_CALL_INTR);
    step(1, 0, PFL_CALL_SUPER);
    step(1, 0, PFL_CALL_LOCAL);
    repeat (5) step(0, 1, PFL_CALL_LOCAL);
    wrap_up();
  end
endmodule
`default_nettype wire
